/* src/fan_duty_arbiter.sv */
// Fan duty arbitration and its registers.
//
// What this block does
// - Hot measurement over limit steps bound duty up
// - New measurement under limit starts stepping down
// - Each processor-hot input has its own binding
// - Doubly bound output takes larger ramp request
// - Manual override takes duty from software value
// - Higher-priority requests may still exceed override
// - Final duty zero to nonzero triggers spin-up unless overridden
// - Spin-up requests programmed duty for programmed time
// - Test enable bit enters parity tree mode
// - Tree output is XOR of listed inputs
// - Bus data and clock pins stay out
// - Reserved registers read zero; unused bits keep written value
// - Undefined-default registers also reset to zero
// - Access types read-only and read/write
// - Each output duty readable as eight bits
// - Override value split into low and high bytes
// - Extended temperature low byte at lower address
// - Sense mode register selects diode or transistor
// - Final duty is maximum of active categories
// - Ramp steps once per programmed interval
// - Duty steps use shared four-bit encoding
`timescale 1ns/1ps
module fan_duty_arbiter
    import fan_duty_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [6:0] bus_addr_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire fan_cfg_t cfg_i,
    input wire hot_meas_t cpu1_hot_input,
    input wire hot_meas_t cpu2_hot_input,
    input wire fan_req_t req_i,
    input wire temps_t temps_i,
    input wire tree_pins_t tree_pins_i,
    output logic [1:0][7:0] fan_duty_o,
    output logic transistor_mode_o,
    output logic parity_test_mode_o,
    output logic parity_tree_o
);
    typedef struct packed {
        tree_pins_t pins_s1;
        tree_pins_t pins_s2;
        logic tree_out;
        logic [7:0] parity_test_control;
        logic [7:0] bus_scratch_test;
        logic [7:0] sense_mode_select;
        logic [1:0][15:0] override_val;
        logic [1:0][7:0] duty;
        logic [1:0] hot_now;
        logic [1:0][1:0] ramp_on;
        logic [1:0][1:0][3:0] ramp_step;
        logic [16:0] tick_cnt;
        logic [7:0] interval_cnt;
        logic [1:0] base_nonzero;
        logic [1:0] spin_on;
        logic [1:0][7:0] spin_cnt;
    } arb_reg_t;

    arb_reg_t r;
    arb_reg_t next_r;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic bus_wr;
    logic [7:0] bus_wr_addr;
    logic [7:0] bus_wr_data;

    mgmt_bus_slave u_bus (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .dev_addr_i(bus_addr_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .wr_o(bus_wr),
        .wr_addr_o(bus_wr_addr),
        .wr_data_o(bus_wr_data)
    );

    function automatic logic [7:0] step_to_duty(input logic [3:0] s);
        if (s == STEP_ZERO) begin
            return DUTY_ZERO;
        end else if (s >= STEP_FULL) begin
            return DUTY_FULL;
        end else begin
            return {4'(s + STEP_OFFSET), 4'h0};
        end
    endfunction : step_to_duty

    // Rounds up so a memorized step never undercuts its source
    function automatic logic [3:0] duty_to_step(input logic [7:0] d);
        logic [4:0] q;
        q = 5'((9'(d) + 9'd15) >> 4);
        if (d == DUTY_ZERO) begin
            return STEP_ZERO;
        end else if (d == DUTY_FULL || q > 5'd16) begin
            return STEP_FULL;
        end else if (q <= 5'(STEP_OFFSET) + 5'd1) begin
            return 4'h1;
        end else begin
            return 4'(q - 5'(STEP_OFFSET));
        end
    endfunction : duty_to_step

    function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a : b;
    endfunction : max8

    logic tick;
    logic step_tick;
    logic [1:0][1:0] bound;
    logic [1:0][7:0] proc8;
    logic [1:0][7:0] others8;
    logic [1:0][7:0] base8;
    logic [1:0][7:0] spin8;
    logic [1:0][7:0] ovr8;

    assign tick = (r.tick_cnt == 17'(TICK_CYCLES_P - 1));
    assign step_tick = tick && (r.interval_cnt + 8'h01 >= cfg_i.ramp_interval_ms);

    assign bound[0] = cfg_i.cpu1_binding;
    assign bound[1] = cfg_i.cpu2_binding;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic [7:0] r0;
            logic [7:0] r1;
            logic [7:0] reg8;
            logic [7:0] lower8;
            assign r0 = (r.ramp_on[ch][0] && bound[0][ch]) ?
                        step_to_duty(r.ramp_step[ch][0]) : DUTY_ZERO;
            assign r1 = (r.ramp_on[ch][1] && bound[1][ch]) ?
                        step_to_duty(r.ramp_step[ch][1]) : DUTY_ZERO;
            assign proc8[ch] = max8(r0, r1);
            assign reg8 = max8(step_to_duty(req_i.regulator_ramp_step[0]),
                               step_to_duty(req_i.regulator_ramp_step[1]));
            assign ovr8[ch] = r.override_val[ch][15:8];
            assign lower8 = cfg_i.override_en[ch] ? ovr8[ch] :
                            step_to_duty(req_i.auto_step[ch]);
            assign spin8[ch] = (r.spin_on[ch] && !cfg_i.override_en[ch]) ?
                               step_to_duty(cfg_i.spin_step) : DUTY_ZERO;
            // upper categories still raise the override
            assign base8[ch] = max8(req_i.full_speed ? DUTY_FULL : DUTY_ZERO,
                                    max8(reg8, max8(proc8[ch], lower8)));
            assign others8[ch] = max8(req_i.full_speed ? DUTY_FULL : DUTY_ZERO,
                                      max8(reg8, max8(lower8, spin8[ch])));
        end
    endgenerate

    always_comb begin
        next_r = r;
        next_r.pins_s1 = tree_pins_i;
        next_r.pins_s2 = r.pins_s1;

        next_r.tree_out = r.parity_test_control[PARITY_ENABLE_POS] & (^r.pins_s2);

        next_r.tick_cnt = tick ? 17'h0_0000 : r.tick_cnt + 17'h0_0001;
        if (step_tick) begin
            next_r.interval_cnt = 8'h00;
        end else if (tick) begin
            next_r.interval_cnt = r.interval_cnt + 8'h01;
        end

        // over-limit state only follows a new measurement
        if (cpu1_hot_input.done) begin
            next_r.hot_now[0] = cpu1_hot_input.over_limit[0];
        end
        if (cpu2_hot_input.done) begin
            next_r.hot_now[1] = cpu2_hot_input.over_limit[1];
        end

        for (int c = 0; c < 2; c++) begin
            for (int h = 0; h < 2; h++) begin
                if (!r.ramp_on[c][h]) begin
                    // enable from memorized request plus one step
                    if (r.hot_now[h] && bound[h][c]) begin
                        next_r.ramp_on[c][h] = 1'b1;
                        next_r.ramp_step[c][h] = (duty_to_step(others8[c]) >= STEP_FULL) ?
                            STEP_FULL : duty_to_step(others8[c]) + 4'h1;
                    end
                end else if (!bound[h][c]) begin
                    next_r.ramp_on[c][h] = 1'b0;
                end else if (!r.hot_now[h] &&
                             step_to_duty(r.ramp_step[c][h]) < others8[c]) begin
                    next_r.ramp_on[c][h] = 1'b0;
                end else if (step_tick) begin
                    if (r.hot_now[h] && r.ramp_step[c][h] < STEP_FULL) begin
                        next_r.ramp_step[c][h] = r.ramp_step[c][h] + 4'h1;
                    end else if (!r.hot_now[h] && r.ramp_step[c][h] > STEP_ZERO) begin
                        next_r.ramp_step[c][h] = r.ramp_step[c][h] - 4'h1;
                    end
                end
            end

            next_r.base_nonzero[c] = (base8[c] != DUTY_ZERO);
            if (!r.base_nonzero[c] && base8[c] != DUTY_ZERO && !cfg_i.override_en[c]) begin
                next_r.spin_on[c] = 1'b1;
                next_r.spin_cnt[c] = 8'h00;
            end else if (r.spin_on[c] && tick) begin
                if (r.spin_cnt[c] + 8'h01 >= cfg_i.spin_time_ms) begin
                    next_r.spin_on[c] = 1'b0;
                end
                next_r.spin_cnt[c] = r.spin_cnt[c] + 8'h01;
            end

            // final is maximum of active requests
            next_r.duty[c] = max8(base8[c], spin8[c]);
        end

        // writable registers; read-only ones ignore writes
        if (bus_wr) begin
            unique case (bus_wr_addr)
                ADDR_PARITY_TEST: next_r.parity_test_control = bus_wr_data;
                ADDR_BUS_SCRATCH: next_r.bus_scratch_test = bus_wr_data;
                ADDR_SENSE_MODE: next_r.sense_mode_select = bus_wr_data;
                ADDR_OUT1_OVR_LOW: next_r.override_val[0][7:0] = bus_wr_data;
                ADDR_OUT1_OVR_HIGH: next_r.override_val[0][15:8] = bus_wr_data;
                ADDR_OUT2_OVR_LOW: next_r.override_val[1][7:0] = bus_wr_data;
                ADDR_OUT2_OVR_HIGH: next_r.override_val[1][15:8] = bus_wr_data;
                default: next_r.bus_scratch_test = r.bus_scratch_test;
            endcase
        end
    end

    always_comb begin
        unique case (rd_addr)
            ADDR_PARITY_TEST: rd_data = r.parity_test_control;
            ADDR_BUS_SCRATCH: rd_data = r.bus_scratch_test;
            ADDR_SENSE_MODE: rd_data = r.sense_mode_select;
            ADDR_CPU1_B_TEMP: rd_data = temps_i.cpu1_diode_b_temp;
            ADDR_CPU2_B_TEMP: rd_data = temps_i.cpu2_diode_b_temp;
            ADDR_CPU1_B_FILT: rd_data = temps_i.cpu1_diode_b_filtered_temp;
            ADDR_CPU2_B_FILT: rd_data = temps_i.cpu2_diode_b_filtered_temp;
            ADDR_OUT1_DUTY: rd_data = r.duty[0];
            ADDR_OUT2_DUTY: rd_data = r.duty[1];
            ADDR_OUT1_OVR_LOW: rd_data = r.override_val[0][7:0];
            ADDR_OUT1_OVR_HIGH: rd_data = r.override_val[0][15:8];
            ADDR_OUT2_OVR_LOW: rd_data = r.override_val[1][7:0];
            ADDR_OUT2_OVR_HIGH: rd_data = r.override_val[1][15:8];
            ADDR_CPU1_A_EXT_LOW: rd_data = temps_i.cpu1_diode_a_ext_temp[7:0];
            ADDR_CPU1_A_EXT_HIGH: rd_data = temps_i.cpu1_diode_a_ext_temp[15:8];
            ADDR_CPU1_B_EXT_LOW: rd_data = temps_i.cpu1_diode_b_ext_temp[7:0];
            ADDR_CPU1_B_EXT_HIGH: rd_data = temps_i.cpu1_diode_b_ext_temp[15:8];
            ADDR_CPU2_A_EXT_LOW: rd_data = temps_i.cpu2_diode_a_ext_temp_low;
            default: rd_data = REG_RESET;
        endcase
    end

    // all registers still get a defined reset here
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign fan_duty_o = r.duty;
    assign transistor_mode_o = r.sense_mode_select[TRANSISTOR_MODE_POS];
    assign parity_test_mode_o = r.parity_test_control[PARITY_ENABLE_POS];
    assign parity_tree_o = r.tree_out;

endmodule : fan_duty_arbiter

/* src/fan_duty_pkg.sv */
// Constants, types and register map.
package fan_duty_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_PARITY_TEST = 8'h00;
    localparam logic [7:0] ADDR_BUS_SCRATCH = 8'h01;
    localparam logic [7:0] ADDR_SENSE_MODE = 8'h05;
    localparam logic [7:0] ADDR_CPU1_B_TEMP = 8'h06;
    localparam logic [7:0] ADDR_CPU2_B_TEMP = 8'h07;
    localparam logic [7:0] ADDR_CPU1_B_FILT = 8'h08;
    localparam logic [7:0] ADDR_CPU2_B_FILT = 8'h09;
    localparam logic [7:0] ADDR_OUT1_DUTY = 8'h0A;
    localparam logic [7:0] ADDR_OUT2_DUTY = 8'h0B;
    localparam logic [7:0] ADDR_OUT1_OVR_LOW = 8'h0C;
    localparam logic [7:0] ADDR_OUT1_OVR_HIGH = 8'h0D;
    localparam logic [7:0] ADDR_OUT2_OVR_LOW = 8'h0E;
    localparam logic [7:0] ADDR_OUT2_OVR_HIGH = 8'h0F;
    localparam logic [7:0] ADDR_CPU1_A_EXT_LOW = 8'h10;
    localparam logic [7:0] ADDR_CPU1_A_EXT_HIGH = 8'h11;
    localparam logic [7:0] ADDR_CPU1_B_EXT_LOW = 8'h12;
    localparam logic [7:0] ADDR_CPU1_B_EXT_HIGH = 8'h13;
    localparam logic [7:0] ADDR_CPU2_A_EXT_LOW = 8'h14;

    // Reset values and field positions
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int PARITY_ENABLE_POS = 0;
    localparam int TRANSISTOR_MODE_POS = 0;

    // Duty step encoding
    localparam logic [3:0] STEP_ZERO = 4'h0;
    localparam logic [3:0] STEP_FULL = 4'hD;
    localparam logic [3:0] STEP_OFFSET = 4'h3;
    localparam logic [7:0] DUTY_ZERO = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hFF;

    // Timing
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_TIME_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;

    // Default bus address, arbitrary value
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2C;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'h0,
        BUS_ADDR = 4'h1,
        BUS_ACK_ADDR = 4'h2,
        BUS_CMD = 4'h3,
        BUS_ACK_CMD = 4'h4,
        BUS_WDATA = 4'h5,
        BUS_ACK_WDATA = 4'h6,
        BUS_RDATA = 4'h7,
        BUS_RACK = 4'h8
    } bus_state_t;

    // Pins folded into the board test tree
    typedef struct packed {
        logic [13:0] cpu_voltage_id_input;
        logic [7:0] gpio;
        logic [1:0] fan_drive_output;
        logic [1:0] processor_hot_signal;
        logic [1:0] regulator_hot_input;
        logic [1:0] general_input_pin;
        logic reset_pin;
    } tree_pins_t;

    typedef struct packed {
        logic [7:0] cpu1_diode_b_temp;
        logic [7:0] cpu2_diode_b_temp;
        logic [7:0] cpu1_diode_b_filtered_temp;
        logic [7:0] cpu2_diode_b_filtered_temp;
        logic [15:0] cpu1_diode_a_ext_temp;
        logic [15:0] cpu1_diode_b_ext_temp;
        logic [7:0] cpu2_diode_a_ext_temp_low;
    } temps_t;

    typedef struct packed {
        logic [1:0] cpu1_binding;
        logic [1:0] cpu2_binding;
        logic [7:0] ramp_interval_ms;
        logic [3:0] spin_step;
        logic [7:0] spin_time_ms;
        logic [1:0] override_en;
    } fan_cfg_t;

    typedef struct packed {
        logic done;
        logic [1:0] over_limit;
    } hot_meas_t;

    typedef struct packed {
        logic full_speed;
        logic [1:0][3:0] regulator_ramp_step;
        logic [1:0][3:0] auto_step;
    } fan_req_t;

endpackage : fan_duty_pkg

/* src/mgmt_bus_slave.sv */
// Two-wire management bus slave with byte register pointer.
`timescale 1ns/1ps
module mgmt_bus_slave
    import fan_duty_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [6:0] dev_addr_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [7:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    output logic wr_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o
);
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_d;
        logic sda_d;
        bus_state_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic rw;
        logic nack;
        logic [7:0] ptr;
        logic oe;
        logic wr;
        logic [7:0] wdata;
    } bus_reg_t;

    bus_reg_t r;
    bus_reg_t next_r;
    logic scl;
    logic sda;
    logic rise;
    logic fall;

    assign scl = r.scl_s[1];
    assign sda = r.sda_s[1];
    assign rise = scl & ~r.scl_d;
    assign fall = ~scl & r.scl_d;

    always_comb begin
        next_r = r;
        next_r.scl_s = {r.scl_s[0], scl_i};
        next_r.sda_s = {r.sda_s[0], sda_i};
        next_r.scl_d = scl;
        next_r.sda_d = sda;
        next_r.wr = 1'b0;
        if (scl && r.scl_d && r.sda_d && !sda) begin
            // Start or repeated start; the pointer survives a repeat
            next_r.st = BUS_ADDR;
            next_r.cnt = 4'h0;
            next_r.oe = 1'b0;
        end else if (scl && r.scl_d && !r.sda_d && sda) begin
            next_r.st = BUS_IDLE;
            next_r.oe = 1'b0;
        end else if (rise) begin
            if (r.st == BUS_ADDR || r.st == BUS_CMD || r.st == BUS_WDATA) begin
                next_r.sh = {r.sh[6:0], sda};
                next_r.cnt = r.cnt + 4'h1;
            end else if (r.st == BUS_RACK) begin
                next_r.nack = sda;
                next_r.ptr = r.ptr + 8'h01;
            end
        end else if (fall) begin
            unique case (r.st)
                BUS_IDLE: begin
                    next_r.oe = 1'b0;
                end
                BUS_ADDR: begin
                    if (r.cnt == 4'h8) begin
                        if (r.sh[7:1] == dev_addr_i) begin
                            next_r.oe = 1'b1;
                            next_r.rw = r.sh[0];
                            next_r.st = BUS_ACK_ADDR;
                        end else begin
                            next_r.st = BUS_IDLE;
                        end
                    end
                end
                BUS_CMD: begin
                    if (r.cnt == 4'h8) begin
                        next_r.ptr = r.sh;
                        next_r.oe = 1'b1;
                        next_r.st = BUS_ACK_CMD;
                    end
                end
                BUS_WDATA: begin
                    if (r.cnt == 4'h8) begin
                        next_r.wr = 1'b1;
                        next_r.wdata = r.sh;
                        next_r.oe = 1'b1;
                        next_r.st = BUS_ACK_WDATA;
                    end
                end
                BUS_ACK_CMD, BUS_ACK_WDATA: begin
                    if (r.st == BUS_ACK_WDATA) begin
                        next_r.ptr = r.ptr + 8'h01;
                    end
                    next_r.oe = 1'b0;
                    next_r.cnt = 4'h0;
                    next_r.st = BUS_WDATA;
                end
                BUS_ACK_ADDR, BUS_RACK: begin
                    if (r.st == BUS_ACK_ADDR && !r.rw) begin
                        next_r.oe = 1'b0;
                        next_r.cnt = 4'h0;
                        next_r.st = BUS_CMD;
                    end else if (r.st == BUS_RACK && r.nack) begin
                        next_r.oe = 1'b0;
                        next_r.st = BUS_IDLE;
                    end else begin
                        next_r.oe = ~rd_data_i[7];
                        next_r.sh = {rd_data_i[6:0], 1'b0};
                        next_r.cnt = 4'h1;
                        next_r.st = BUS_RDATA;
                    end
                end
                BUS_RDATA: begin
                    if (r.cnt == 4'h8) begin
                        next_r.oe = 1'b0;
                        next_r.st = BUS_RACK;
                    end else begin
                        next_r.oe = ~r.sh[7];
                        next_r.sh = {r.sh[6:0], 1'b0};
                        next_r.cnt = r.cnt + 4'h1;
                    end
                end
                default: begin
                    next_r.st = BUS_IDLE;
                    next_r.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '{scl_s: 2'b11, sda_s: 2'b11, scl_d: 1'b1, sda_d: 1'b1, st: BUS_IDLE,
                   default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = r.oe;
    assign rd_addr_o = r.ptr;
    assign wr_o = r.wr;
    assign wr_addr_o = r.ptr;
    assign wr_data_o = r.wdata;

endmodule : mgmt_bus_slave

/* test/bus_host.sv */
// Two-wire bus host model.
`timescale 1ns/1ps
module bus_host
    import fan_duty_pkg::*;
(
    input wire logic clk_i,
    input wire logic dev_oe_i,
    output logic scl_o,
    output logic sda_o
);
    logic pull_low = 1'b0;
    logic ack_bit;
    logic [7:0] junk;
    initial scl_o = 1'b1;
    // Pulled-up line: high unless either side pulls it low
    assign sda_o = !(pull_low || dev_oe_i);
    // Slow halves outlast the synchroniser delay
    task automatic half();
        repeat (8) @(posedge clk_i);
    endtask : half
    task automatic bit_io(input logic b, output logic r);
        half();
        pull_low <= !b;
        half();
        scl_o <= 1'b1;
        half();
        r = sda_o;
        scl_o <= 1'b0;
    endtask : bit_io
    // Start when s is high, stop otherwise
    task automatic frame(input logic s);
        half();
        pull_low <= !s;
        half();
        scl_o <= 1'b1;
        half();
        pull_low <= s;
        half();
        scl_o <= !s;
    endtask : frame
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(1'b1, ack_bit);
    endtask : xfer
    // A read's released ninth bit is the closing no-acknowledge
    task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] wd,
                          output logic [7:0] q);
        frame(1'b1);
        xfer({BUS_ADDR_DEFAULT, 1'b0}, junk);
        xfer(a, junk);
        if (rd) frame(1'b1);
        xfer(rd ? {BUS_ADDR_DEFAULT, 1'b1} : wd, junk);
        if (rd) xfer(8'hFF, q);
        frame(1'b0);
    endtask : access
endmodule : bus_host

/* test/fan_duty_arbiter_bench.sv */
// Self-checking bench.
`timescale 1ns/1ps
module fan_duty_arbiter_bench
    import fan_duty_pkg::*;
;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic scl_i, sda_i, sda_oe_o, transistor_mode_o, parity_test_mode_o, parity_tree_o;
    logic [1:0][7:0] fan_duty_o;
    logic [7:0] d;
    int num_errors = 0;
    int checks = 0;
    fan_cfg_t cfg_i = '0;
    hot_meas_t cpu1_hot_input = '0;
    hot_meas_t cpu2_hot_input = '0;
    fan_req_t req_i = '0;
    tree_pins_t tree_pins_i = '0;
    temps_t temps_i = {8'h21, 8'h32, 8'h43, 8'h54, 16'h6576, 16'h8798, 8'hA9};
    logic [7:0] reg_tab [21] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h32,
        8'h43, 8'h54, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h76, 8'h65, 8'h98, 8'h87,
        8'hA9};
    fan_duty_arbiter #(.TICK_CYCLES_P(10)) dut (.*, .bus_addr_i(BUS_ADDR_DEFAULT), .sda_o());
    bus_host host (.clk_i, .dev_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
    always #4 clk_i = ~clk_i;
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] v);
        host.access(1'b0, a, v, d);
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.access(1'b1, a, 8'h00, d);
        chk("register", exp, d);
    endtask : rd_chk
    task t_regs();
        for (int a = 0; a < 21; a++) rd_chk(8'(a), reg_tab[a]);
        $display("regs done");
    endtask : t_regs
    task t_access();
        wr(ADDR_BUS_SCRATCH, 8'hA5);
        rd_chk(ADDR_BUS_SCRATCH, 8'hA5);
        wr(ADDR_OUT1_DUTY, 8'h55);
        rd_chk(ADDR_OUT1_DUTY, 8'h00);
        wr(ADDR_SENSE_MODE, 8'h01);
        chk("transistor mode", 8'h01, 8'(transistor_mode_o));
        wr(ADDR_SENSE_MODE, 8'h00);
        $display("access done");
    endtask : t_access
    task t_parity();
        wr(ADDR_PARITY_TEST, 8'h01);
        chk("test mode", 8'h01, 8'(parity_test_mode_o));
        for (int i = 0; i < 4; i++) begin
            tree_pins_i <= tree_pins_i ^ (31'h7 << (i * 7));
            repeat (6) @(posedge clk_i);
            chk("tree", 8'(^tree_pins_i), 8'(parity_tree_o));
        end
        rd_chk(ADDR_PARITY_TEST, 8'h01);
        wr(ADDR_PARITY_TEST, 8'h00);
        chk("tree idle", 8'h00, 8'(parity_tree_o));
        $display("parity done");
    endtask : t_parity
    task t_prio();
        req_i.full_speed <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("full speed", DUTY_FULL, fan_duty_o[1]);
        req_i <= {1'b0, 4'h0, 4'h7, 4'h2, 4'h0};
        repeat (3) @(posedge clk_i);
        chk("regulator", 8'hA0, fan_duty_o[0]);
        wr(ADDR_OUT1_OVR_LOW, 8'h0F);
        wr(ADDR_OUT1_OVR_HIGH, 8'h30);
        rd_chk(ADDR_OUT1_OVR_LOW, 8'h0F);
        cfg_i.override_en[0] <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("over override", 8'hA0, fan_duty_o[0]);
        req_i <= {1'b0, 4'h0, 4'h0, 4'h2, 4'h9};
        repeat (3) @(posedge clk_i);
        chk("override", 8'h30, fan_duty_o[0]);
        chk("auto", 8'h50, fan_duty_o[1]);
        rd_chk(ADDR_OUT1_DUTY, 8'h30);
        cfg_i.override_en[0] <= 1'b0;
        req_i <= '0;
        $display("prio done");
    endtask : t_prio
    task t_spin();
        // Let the final duty fall to zero first
        repeat (3) @(posedge clk_i);
        cfg_i.spin_step <= STEP_FULL;
        cfg_i.spin_time_ms <= 8'h02;
        req_i.auto_step[0] <= 4'h1;
        repeat (4) @(posedge clk_i);
        chk("spin duty", DUTY_FULL, fan_duty_o[0]);
        repeat (30) @(posedge clk_i);
        chk("after spin", 8'h40, fan_duty_o[0]);
        cfg_i.spin_step <= STEP_ZERO;
        $display("spin done");
    endtask : t_spin
    task t_hot();
        cfg_i.cpu1_binding <= 2'b01;
        cfg_i.cpu2_binding <= 2'b10;
        cfg_i.ramp_interval_ms <= 8'h01;
        cpu1_hot_input <= 3'b101;
        @(posedge clk_i);
        cpu1_hot_input.done <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("bound rise", 8'h01, 8'(fan_duty_o[0] > 8'h40));
        chk("unbound", 8'h00, fan_duty_o[1]);
        repeat (200) @(posedge clk_i);
        chk("ramp top", DUTY_FULL, fan_duty_o[0]);
        cpu1_hot_input <= 3'b100;
        cpu2_hot_input <= 3'b110;
        @(posedge clk_i);
        cpu1_hot_input.done <= 1'b0;
        cpu2_hot_input.done <= 1'b0;
        repeat (200) @(posedge clk_i);
        chk("ramp down", 8'h40, fan_duty_o[0]);
        chk("second input", DUTY_FULL, fan_duty_o[1]);
        $display("hot done");
    endtask : t_hot
    task summarize();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    initial begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_regs();
        t_access();
        t_parity();
        t_prio();
        t_spin();
        t_hot();
        summarize();
    end
    // Tests take about 31k cycles
    initial begin
        #600_000;
        num_errors++;
        summarize();
    end
endmodule : fan_duty_arbiter_bench

/* test/fan_duty_chk.sv */
// Port assertions.
`timescale 1ns/1ps
module fan_duty_chk
    import fan_duty_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire fan_cfg_t cfg_i,
    input wire hot_meas_t cpu1_hot_input,
    input wire hot_meas_t cpu2_hot_input,
    input wire fan_req_t req_i,
    input wire tree_pins_t tree_pins_i,
    input wire logic [1:0][7:0] fan_duty_o,
    input wire logic parity_test_mode_o,
    input wire logic parity_tree_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    function automatic logic [7:0] duty_of(input logic [3:0] s);
        return (s == STEP_ZERO) ? DUTY_ZERO : (s >= STEP_FULL) ? DUTY_FULL :
            {4'(s + STEP_OFFSET), 4'h0};
    endfunction : duty_of
    a_full_speed_max: assert property (
        req_i.full_speed |=> fan_duty_o == {DUTY_FULL, DUTY_FULL})
        else $error("full speed lost");
    a_regulator_floor: assert property (
        fan_duty_o[0] >= duty_of($past(req_i.regulator_ramp_step[0])))
        else $error("regulator lost");
    a_auto_floor: assert property (
        !cfg_i.override_en[0] |=> fan_duty_o[0] >= duty_of($past(req_i.auto_step[0])))
        else $error("auto lost");
    a_spin_on_start: assert property (
        $rose(|fan_duty_o[0]) && !cfg_i.override_en[0]
        |-> ##[0:2] fan_duty_o[0] >= duty_of(cfg_i.spin_step))
        else $error("no spin-up");
    a_hot_raise_one: assert property (
        cpu1_hot_input.done && cpu1_hot_input.over_limit[0] && cfg_i.cpu1_binding[0]
        |-> ##3 fan_duty_o[0] != DUTY_ZERO && fan_duty_o[0] >= $past(fan_duty_o[0], 3))
        else $error("no hot raise");
    a_hot_raise_two: assert property (
        cpu2_hot_input.done && cpu2_hot_input.over_limit[1] && cfg_i.cpu2_binding[1]
        |-> ##3 fan_duty_o[1] != DUTY_ZERO && fan_duty_o[1] >= $past(fan_duty_o[1], 3))
        else $error("no second hot raise");
    a_tree_idle_low: assert property (
        !parity_test_mode_o && !$past(parity_test_mode_o) |-> !parity_tree_o)
        else $error("test pin active");
    a_tree_parity: assert property (
        (parity_test_mode_o && $stable(tree_pins_i)) [*5] |-> parity_tree_o == ^tree_pins_i)
        else $error("parity wrong");
endmodule : fan_duty_chk

bind fan_duty_arbiter fan_duty_chk chk (.*);
